/* File: hdl/vco_cal_pkg.sv */
/*
 * shared constants and carriers for the calibration and test register bank:
 * register offsets, reset values, field positions, serial frame layout,
 * probe select codes and the packed structs passed between the modules.
 * assumes it is compiled before any design file that names it.
 */
package vco_cal_pkg;

    // ------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 24;            // rw flag, 15 address bits, 8 data bits
    localparam int HEAD_BITS = 16;             // rw flag plus address
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic [4:0] CNT_HEAD = 5'h10;   // bits counted when the header is complete
    localparam logic [4:0] CNT_FRAME = 5'h18;  // bits counted when the frame is complete

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [14:0] OFS_ADC_CLK_DIV = 15'h0035;
    localparam logic [14:0] OFS_CP_ADJUST = 15'h0036;
    localparam logic [14:0] OFS_TEST_BAND = 15'h0037;
    localparam logic [14:0] OFS_CORE_BIAS = 15'h0038;
    localparam logic [14:0] OFS_MUX_TUNE = 15'h0039;
    localparam logic [14:0] OFS_ADC_OFFSET = 15'h003a;
    localparam logic [14:0] OFS_PUMP_TEST = 15'h003e;
    localparam logic [14:0] OFS_RSVD_A = 15'h003f;
    localparam logic [14:0] OFS_RSVD_B = 15'h0040;
    localparam logic [14:0] OFS_RSVD_C = 15'h0041;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ADC_CLK_DIV = 8'h4c;
    localparam logic [7:0] RST_CP_ADJUST = 8'h30;
    localparam logic [7:0] RST_TEST_BAND = 8'h00;
    localparam logic [7:0] RST_CORE_BIAS = 8'h00;
    localparam logic [7:0] RST_MUX_TUNE = 8'h07;
    localparam logic [7:0] RST_ADC_OFFSET = 8'h55;
    localparam logic [7:0] RST_PUMP_TEST = 8'h0c;
    localparam logic [7:0] RST_RSVD_A = 8'h80;
    localparam logic [7:0] RST_RSVD_B = 8'h50;
    localparam logic [7:0] RST_RSVD_C = 8'h28;

    // ------------------------------------------------------------
    // field positions and write masks
    // ------------------------------------------------------------
    localparam int CORE_LSB = 4;               // core one-hot in [7:4]
    localparam int BIAS_LSB = 0;               // bias code in [3:0]
    localparam int PROBE_LSB = 4;              // probe select in [6:4]
    localparam int TUNE_LSB = 0;               // tune target in [3:0]
    localparam int PUMP_LSB = 2;               // pump test setting in [3:2]
    localparam logic [7:0] MASK_MUX_TUNE = 8'h7f;   // top bit reads zero
    localparam logic [7:0] MASK_PUMP_TEST = 8'h0c;  // only [3:2] writable

    // ------------------------------------------------------------
    // probe select codes and pump modes
    // ------------------------------------------------------------
    localparam logic [2:0] PRB_BUSY = 3'h0;
    localparam logic [2:0] PRB_N_BAND = 3'h1;
    localparam logic [2:0] PRB_R_BAND = 3'h2;
    localparam logic [2:0] PRB_RSVD = 3'h3;
    localparam logic [2:0] PRB_TIMEOUT = 3'h4;
    localparam logic [2:0] PRB_BIAS_MIN = 3'h5;
    localparam logic [2:0] PRB_ADC_BUSY = 3'h6;
    localparam logic [2:0] PRB_LOW = 3'h7;
    localparam logic [1:0] PUMP_TRISTATE = 2'h0;
    localparam logic [1:0] PUMP_NORMAL = 2'h3;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] band;        // core band
        logic [3:0] core_onehot; // bit 3 core a .. bit 0 core d
        logic [3:0] bias_code;   // 0 max bias, f min bias
        logic [3:0] tune_target; // 0.58 v plus 0.15 v per step
    } cal_set_s;

    typedef struct packed {
        logic busy;
        logic n_band;
        logic r_band;
        logic timeout_clk;
        logic bias_min;
        logic adc_busy;
    } probe_s;

endpackage

/* File: hdl/serial_port.sv */
/*
 * serial control port slave: 24 bit frames, msb first, sampled on rising
 * serial clock, read data shifted out on falling serial clock.
 * assumes the serial clock is far slower than clk (at least 8 clk per half
 * period) so that both edges are seen after the two flop synchronisers.
 */
`timescale 1ns/1ns
module serial_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pins
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // register side
    output logic wr_stb,
    output logic rd_stb,
    output logic [14:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_sync;     // [0] feeds [1] only
    logic [1:0] cs_sync;
    logic [1:0] sdi_sync;
    logic sclk_last;           // previous synchronised level
    logic [4:0] bit_cnt;       // bits taken in this frame
    logic [23:0] shift_in;     // incoming frame
    logic [7:0] shift_out;     // read data on its way out
    logic reading;             // header asked for a read

    wire sclk_rise = sclk_sync[1] & ~sclk_last;
    wire sclk_fall = ~sclk_sync[1] & sclk_last;
    wire selected = ~cs_sync[1];
    wire [23:0] next_shift = {shift_in[22:0], sdi_sync[1]};
    wire [4:0] next_cnt = bit_cnt + 5'h01;
    wire head_done = sclk_rise & selected & (next_cnt == vco_cal_pkg::CNT_HEAD);
    wire frame_done = sclk_rise & selected & (next_cnt == vco_cal_pkg::CNT_FRAME);

    // two flops on every pin before use
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            sdi_sync <= 2'h0;
            sclk_last <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], sclk};
            cs_sync <= {cs_sync[0], cs_b};
            sdi_sync <= {sdi_sync[0], sdi};
            sclk_last <= sclk_sync[1];
        end
    end

    // ------------------------------------------------------------
    // frame shifter
    // ------------------------------------------------------------
    // deselect restarts the count, so a short frame is simply dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt <= 5'h00;
            shift_in <= 24'h000000;
        end else if (!selected) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise && bit_cnt != vco_cal_pkg::CNT_FRAME) begin
            bit_cnt <= next_cnt;
            shift_in <= next_shift;
        end
    end

    // register side strobes and captured fields
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            addr <= 15'h0000;
            wdata <= 8'h00;
            reading <= 1'b0;
        end else begin
            wr_stb <= frame_done & ~reading;
            rd_stb <= head_done & next_shift[15];
            if (head_done) begin
                addr <= next_shift[14:0];
                reading <= next_shift[15];
            end else if (!selected) begin
                reading <= 1'b0;
            end
            if (frame_done) begin
                wdata <= next_shift[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read data out
    // ------------------------------------------------------------
    // loaded the cycle after the header, first bit driven on the next fall
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_out <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= selected & reading;
            if (rd_stb) begin
                shift_out <= rdata;
            end else if (sclk_fall && reading && selected) begin
                sdo <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

endmodule // serial_port

/* File: hdl/adc_clk_gen.sv */
/*
 * calibration adc clock generator: toggles every 2*div+1 clk cycles so the
 * full period is 4*div+2 cycles of the phase detector clock.
 * assumes clk is the phase detector clock and div comes from a register.
 */
`timescale 1ns/1ns
module adc_clk_gen #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic [DIV_W-1:0] div,
    // output
    output logic adc_clk
);

    // ------------------------------------------------------------
    // half period counter
    // ------------------------------------------------------------
    logic [DIV_W:0] half_cnt;   // counts up to 2*div
    wire [DIV_W:0] half_last = {div, 1'b0};
    wire [DIV_W:0] next_half_cnt = (half_cnt >= half_last) ? '0 : half_cnt + 1'b1;

    // a new divider value takes effect at once, in the current half period
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_cnt <= '0;
            adc_clk <= 1'b0;
        end else begin
            half_cnt <= next_half_cnt;
            if (half_cnt >= half_last) begin
                adc_clk <= ~adc_clk;
            end
        end
    end

endmodule // adc_clk_gen

/* File: hdl/vco_cal_test_config_regs.sv */
/*
 * calibration and test configuration register bank of the synthesizer:
 * adc clock divider, adc offset correction, test overrides for core, band,
 * bias and tune target, calibration probe mux, charge pump test mode and
 * the reserved registers, all reached over the serial control port.
 * assumes clk is the phase detector clock, test_mode_en and the automatic
 * calibration values come from logic on the same clock.
 */
// Overview of operation
// - adc clock is clk over four div plus two
// - band field overrides calibration only in test mode
// - one-hot core select, zero turns all off
// - bias code, zero maximum, fifteen minimum
// - three-bit select routes calibration signal to probe
// - tune target code in test mode, resets seven
// - offset value corrects the adc result
// - pump test field, zero tristate, three normal
// - register 0x40 is read-only, reads 0x50
// - mux and tune register resets 0x07, top zero
`timescale 1ns/1ns
module vco_cal_test_config_regs #(
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // serial control port pins
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // calibration state machine side
    input wire logic test_mode_en,
    input wire vco_cal_pkg::cal_set_s auto_cal,
    input wire vco_cal_pkg::probe_s probes,
    // adc result path
    input wire logic [DATA_W-1:0] adc_raw,
    input wire logic adc_raw_valid,
    output logic [DATA_W-1:0] adc_corrected,
    output logic adc_corrected_valid,
    output logic adc_clk,
    // settings to the analog side
    output vco_cal_pkg::cal_set_s cal_set,
    output logic probe_out,
    output logic [1:0] pump_test_setting,
    output logic [7:0] pump_current_trim,
    output logic [7:0] reserved_a,
    output logic [7:0] reserved_c
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] cal_adc_clock_divider;     // adc clock divider
    logic [7:0] cp_adjust_offset_reserved; // pump trim, left at default
    logic [7:0] test_band_select;          // forced band
    logic [7:0] test_core_and_bias;        // forced core and bias
    logic [7:0] test_mux_and_tune_target;  // probe select and forced tune
    logic [7:0] cal_adc_offset;            // adc offset correction
    logic [7:0] charge_pump_test;          // pump test mode
    logic [7:0] reserved_rw_a;             // reserved, writable
    logic [7:0] reserved_c_reg;            // reserved, writable

    // serial port to register side
    logic wr_stb;
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    // ------------------------------------------------------------
    // serial port and adc clock
    // ------------------------------------------------------------
    serial_port u_port (
        .clk(clk),
        .rst_b(rst_b),
        .sclk(sclk),
        .cs_b(cs_b),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .wr_stb(wr_stb),
        .rd_stb(),
        .addr(addr),
        .wdata(wdata),
        .rdata(rdata)
    );

    adc_clk_gen #(
        .DIV_W(8)
    ) u_adc_clk (
        .clk(clk),
        .rst_b(rst_b),
        .div(cal_adc_clock_divider),
        .adc_clk(adc_clk)
    );

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire hit_div = (addr == vco_cal_pkg::OFS_ADC_CLK_DIV);
    wire hit_cp = (addr == vco_cal_pkg::OFS_CP_ADJUST);
    wire hit_band = (addr == vco_cal_pkg::OFS_TEST_BAND);
    wire hit_core = (addr == vco_cal_pkg::OFS_CORE_BIAS);
    wire hit_mux = (addr == vco_cal_pkg::OFS_MUX_TUNE);
    wire hit_ofs = (addr == vco_cal_pkg::OFS_ADC_OFFSET);
    wire hit_pump = (addr == vco_cal_pkg::OFS_PUMP_TEST);
    wire hit_ra = (addr == vco_cal_pkg::OFS_RSVD_A);
    wire hit_rb = (addr == vco_cal_pkg::OFS_RSVD_B);
    wire hit_rc = (addr == vco_cal_pkg::OFS_RSVD_C);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // the read-only reserved register at 0x40 has no storage at all
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_adc_clock_divider <= vco_cal_pkg::RST_ADC_CLK_DIV;
            cp_adjust_offset_reserved <= vco_cal_pkg::RST_CP_ADJUST;
            test_band_select <= vco_cal_pkg::RST_TEST_BAND;
            test_core_and_bias <= vco_cal_pkg::RST_CORE_BIAS;
            test_mux_and_tune_target <= vco_cal_pkg::RST_MUX_TUNE;
            cal_adc_offset <= vco_cal_pkg::RST_ADC_OFFSET;
            charge_pump_test <= vco_cal_pkg::RST_PUMP_TEST;
            reserved_rw_a <= vco_cal_pkg::RST_RSVD_A;
            reserved_c_reg <= vco_cal_pkg::RST_RSVD_C;
        end else if (wr_stb) begin
            if (hit_div) begin
                cal_adc_clock_divider <= wdata;
            end
            if (hit_cp) begin
                cp_adjust_offset_reserved <= wdata;
            end
            if (hit_band) begin
                test_band_select <= wdata;
            end
            if (hit_core) begin
                test_core_and_bias <= wdata;
            end
            if (hit_mux) begin
                test_mux_and_tune_target <= wdata & vco_cal_pkg::MASK_MUX_TUNE;
            end
            if (hit_ofs) begin
                cal_adc_offset <= wdata;
            end
            if (hit_pump) begin
                charge_pump_test <= wdata & vco_cal_pkg::MASK_PUMP_TEST;
            end
            if (hit_ra) begin
                reserved_rw_a <= wdata;
            end
            if (hit_rc) begin
                reserved_c_reg <= wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // unmapped offsets read as zero; sampled by the port on rd_stb
    assign rdata = hit_div ? cal_adc_clock_divider :
                   hit_cp ? cp_adjust_offset_reserved :
                   hit_band ? test_band_select :
                   hit_core ? test_core_and_bias :
                   hit_mux ? test_mux_and_tune_target :
                   hit_ofs ? cal_adc_offset :
                   hit_pump ? charge_pump_test :
                   hit_ra ? reserved_rw_a :
                   hit_rb ? vco_cal_pkg::RST_RSVD_B :
                   hit_rc ? reserved_c_reg :
                   8'h00;

    // ------------------------------------------------------------
    // override selection
    // ------------------------------------------------------------
    wire vco_cal_pkg::cal_set_s forced = '{
        band: test_band_select,
        core_onehot: test_core_and_bias[vco_cal_pkg::CORE_LSB +: 4],
        bias_code: test_core_and_bias[vco_cal_pkg::BIAS_LSB +: 4],
        tune_target: test_mux_and_tune_target[vco_cal_pkg::TUNE_LSB +: 4]
    };
    // a zero core field passes through, switching every core off
    wire vco_cal_pkg::cal_set_s next_cal_set = test_mode_en ? forced : auto_cal;

    // ------------------------------------------------------------
    // probe mux
    // ------------------------------------------------------------
    wire [2:0] cal_probe_select = test_mux_and_tune_target[vco_cal_pkg::PROBE_LSB +: 3];

    function automatic logic probe_pick(input logic [2:0] sel, input vco_cal_pkg::probe_s p);
        logic pick;
        pick = 1'b0;
        unique case (sel)
            vco_cal_pkg::PRB_BUSY: pick = p.busy;
            vco_cal_pkg::PRB_N_BAND: pick = p.n_band;
            vco_cal_pkg::PRB_R_BAND: pick = p.r_band;
            vco_cal_pkg::PRB_RSVD: pick = 1'b0;     // reserved code drives low
            vco_cal_pkg::PRB_TIMEOUT: pick = p.timeout_clk;
            vco_cal_pkg::PRB_BIAS_MIN: pick = p.bias_min;
            vco_cal_pkg::PRB_ADC_BUSY: pick = p.adc_busy;
            vco_cal_pkg::PRB_LOW: pick = 1'b0;
        endcase
        return pick;
    endfunction

    wire next_probe = probe_pick(cal_probe_select, probes);

    // ------------------------------------------------------------
    // adc offset correction
    // ------------------------------------------------------------
    // subtract with floor at zero so a small reading cannot wrap to full scale
    wire [DATA_W:0] adc_diff = {1'b0, adc_raw} - {1'b0, cal_adc_offset};
    wire [DATA_W-1:0] next_adc = adc_diff[DATA_W] ? '0 : adc_diff[DATA_W-1:0];

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // one cycle of latency on every setting keeps the outputs glitch free
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_set <= '0;
            probe_out <= 1'b0;
            pump_test_setting <= vco_cal_pkg::PUMP_NORMAL;
            pump_current_trim <= vco_cal_pkg::RST_CP_ADJUST;
            reserved_a <= vco_cal_pkg::RST_RSVD_A;
            reserved_c <= vco_cal_pkg::RST_RSVD_C;
            adc_corrected <= '0;
            adc_corrected_valid <= 1'b0;
        end else begin
            cal_set <= next_cal_set;
            probe_out <= next_probe;
            pump_test_setting <= charge_pump_test[vco_cal_pkg::PUMP_LSB +: 2];
            pump_current_trim <= cp_adjust_offset_reserved;
            reserved_a <= reserved_rw_a;
            reserved_c <= reserved_c_reg;
            adc_corrected_valid <= adc_raw_valid;
            if (adc_raw_valid) begin
                adc_corrected <= next_adc;
            end
        end
    end

endmodule // vco_cal_test_config_regs

/* File: tb/vco_cal_test_config_regs_assertions.sv */
/* concurrent checks on the calibration register bank ports.
   assumes it is bound into every vco_cal_test_config_regs. */
`timescale 1ns/1ns
module vco_cal_test_config_regs_chk #(
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // watched ports
    input wire logic cs_b,
    input wire logic test_mode_en,
    input wire vco_cal_pkg::cal_set_s auto_cal,
    input wire vco_cal_pkg::probe_s probes,
    input wire logic [DATA_W-1:0] adc_raw,
    input wire logic adc_raw_valid,
    input wire logic [DATA_W-1:0] adc_corrected,
    input wire logic adc_corrected_valid,
    input wire logic adc_clk,
    input wire vco_cal_pkg::cal_set_s cal_set,
    input wire logic probe_out,
    input wire logic [1:0] pump_test_setting,
    input wire logic [7:0] pump_current_trim
);
    // one clock domain, so one default for all
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // corrected word follows every raw word
    property p_adc_valid;
        adc_raw_valid |=> adc_corrected_valid;
    endproperty
    a_adc_valid: assert property (p_adc_valid) else $error("adc valid missing");
    property p_adc_only;
        adc_corrected_valid |-> $past(adc_raw_valid);
    endproperty
    a_adc_only: assert property (p_adc_only) else $error("adc valid unasked");
    // subtraction can never raise the word
    property p_adc_le;
        adc_raw_valid |=> adc_corrected <= $past(adc_raw);
    endproperty
    a_adc_le: assert property (p_adc_le) else $error("adc word grew");
    // outside test mode the calibration values pass through
    property p_cal_auto;
        !test_mode_en |=> cal_set == $past(auto_cal);
    endproperty
    a_cal_auto: assert property (p_cal_auto) else $error("auto values lost");
    // forced values ignore auto side while the port is idle
    property p_cal_hold;
        test_mode_en && $past(test_mode_en) && $past(rst_b) && cs_b && $past(cs_b, 4)
            |=> $stable(cal_set);
    endproperty
    a_cal_hold: assert property (p_cal_hold) else $error("forced values moved");
    property p_probe;
        probe_out |-> $past(probes) != 6'h00;
    endproperty
    a_probe: assert property (p_probe) else $error("probe high from nothing");
    // reset divider gives a long first half period
    property p_adc_first;
        $rose(rst_b) |-> !adc_clk [*8];
    endproperty
    a_adc_first: assert property (p_adc_first) else $error("adc clock early");
    property p_pump_rst;
        $rose(rst_b) |-> pump_test_setting == 2'h3 && pump_current_trim == 8'h30;
    endproperty
    a_pump_rst: assert property (p_pump_rst) else $error("pump reset wrong");
    c_mode: cover property (test_mode_en ##1 !test_mode_en);
    c_b2b: cover property (adc_raw_valid [*2]);
    c_probe: cover property (probe_out);
endmodule // vco_cal_test_config_regs_chk
bind vco_cal_test_config_regs vco_cal_test_config_regs_chk #(.DATA_W(DATA_W)) chk_i (.*);

/* File: tb/tb.sv */
/* self-checking bench driving the serial port and adc path.
   assumes the bank is the top design and needs no partner. */
`timescale 1ns/1ns
module tb;
    logic clk, rst_b, sclk, cs_b, sdi, sdo, sdo_oe, test_mode_en;
    logic adc_raw_valid, adc_corrected_valid, adc_clk, probe_out;
    logic [7:0] adc_raw, adc_corrected, pump_current_trim, reserved_a, reserved_c, q;
    logic [1:0] pump_test_setting;
    vco_cal_pkg::cal_set_s auto_cal, cal_set;
    vco_cal_pkg::probe_s probes;
    int miscompares, n_tests, n;
    // offsets, reset reads and reads after writing f3 (pump trim kept, last is unmapped)
    logic [7:0] ofs [11] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3e, 8'h3f, 8'h40,
        8'h41, 8'h42};
    logic [7:0] rv [11] = '{8'h4c, 8'h30, 8'h00, 8'h00, 8'h07, 8'h55, 8'h0c, 8'h80, 8'h50,
        8'h28, 8'h00};
    logic [7:0] wv [11] = '{8'hf3, 8'h30, 8'hf3, 8'hf3, 8'h73, 8'hf3, 8'h00, 8'hf3, 8'h50,
        8'hf3, 8'h00};
    logic [3:0] cores [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    logic [5:0] pm [8] = '{6'h20, 6'h10, 6'h08, 6'h00, 6'h04, 6'h02, 6'h01, 6'h00};
    logic [7:0] raws [5] = '{8'h50, 8'h10, 8'h05, 8'hff, 8'h11};
    logic [7:0] dv [2] = '{8'h02, 8'h00};

    vco_cal_test_config_regs vco_cal_test_config_regs_i (.*);

    // 250 mhz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [19:0] s, input logic [19:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // inputs always move 1 ns after the edge
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // one 24 bit frame; half periods of 10 clk suit the synchronisers
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d);
        logic [23:0] f;
        f = {rd, 7'h00, a, d};
        cs_b = 1'b0;
        cyc(4);
        for (int i = 23; i >= 0; i--) begin
            sdi = f[i];
            cyc(10);
            if (i < 8) q[i] = sdo;
            if (i == 7) chk(sdo_oe, rd);
            sclk = 1'b1;
            cyc(10);
            sclk = 1'b0;
        end
        cyc(12);
        cs_b = 1'b1;
        cyc(10);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // bounded wait for an adc clock level, counting cycles
    task automatic wait_lvl(input logic v, output int c);
        c = 0;
        while (adc_clk !== v) begin
            cyc(1);
            c++;
            if (c > 2000) begin
                miscompares++;
                end_of_test();
            end
        end
    endtask

    initial begin
        {rst_b, sclk, sdi, test_mode_en, adc_raw_valid, adc_raw, probes} = '0;
        cs_b = 1'b1;
        auto_cal = 20'h5a3c6;
        miscompares = 0;
        n_tests = 0;
        cyc(12);
        rst_b = 1'b1;
        cyc(3);
        chk(pump_test_setting, 2'h3);
        chk(pump_current_trim, 8'h30);
        for (int i = 0; i < 11; i++) begin
            xfer(1'b1, ofs[i], 8'h00);
            chk(q, rv[i]);
        end
        $display("reset values done");
        for (int i = 0; i < 11; i++) xfer(1'b0, ofs[i], (i == 1) ? 8'h30 : 8'hf3);
        for (int i = 0; i < 11; i++) begin
            xfer(1'b1, ofs[i], 8'h00);
            chk(q, wv[i]);
        end
        chk(pump_test_setting, 2'h0);
        chk(pump_current_trim, 8'h30);
        chk(reserved_a, 8'hf3);
        chk(reserved_c, 8'hf3);
        $display("write readback done");
        test_mode_en = 1'b1;
        xfer(1'b0, 8'h37, 8'ha5);
        xfer(1'b0, 8'h39, 8'h0c);
        for (int j = 0; j < 5; j++) begin
            xfer(1'b0, 8'h38, {cores[j], {4{j[0]}}});
            chk(cal_set.band, 8'ha5);
            chk(cal_set.core_onehot, cores[j]);
            chk(cal_set.bias_code, {4{j[0]}});
            chk(cal_set.tune_target, 4'hc);
        end
        for (int c = 0; c < 8; c++) begin
            xfer(1'b0, 8'h39, {1'b0, c[2:0], 4'h7});
            probes = pm[c];
            cyc(2);
            chk(probe_out, pm[c] != 6'h00);
            probes = ~pm[c];
            cyc(2);
            chk(probe_out, 1'b0);
        end
        test_mode_en = 1'b0;
        cyc(2);
        chk(cal_set, auto_cal);
        auto_cal = 20'ha5c39;
        cyc(2);
        chk(cal_set, auto_cal);
        $display("test mode and probe done");
        xfer(1'b0, 8'h3a, 8'h10);
        for (int i = 0; i < 5; i++) begin
            adc_raw = raws[i];
            adc_raw_valid = 1'b1;
            cyc(1);
            chk(adc_corrected, (raws[i] > 8'h10) ? raws[i] - 8'h10 : 8'h00);
            chk(adc_corrected_valid, 1'b1);
        end
        adc_raw_valid = 1'b0;
        cyc(1);
        chk(adc_corrected_valid, 1'b0);
        $display("adc offset done");
        for (int k = 0; k < 2; k++) begin
            xfer(1'b0, 8'h35, dv[k]);
            wait_lvl(1'b0, n);
            wait_lvl(1'b1, n);
            wait_lvl(1'b0, n);
            chk(20'(n), 20'(2 * dv[k] + 1));
            wait_lvl(1'b1, n);
            chk(20'(n), 20'(2 * dv[k] + 1));
        end
        $display("adc clock done");
        end_of_test();
    end
endmodule // tb
